// ==== pkg/rcs_defs.svh ====
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// ----------------------------------------------------------------
// clock and measurement cycle
// ----------------------------------------------------------------
`define RCS_CLK_MHZ          100
`define RCS_MEAS_PERIOD_MS   1000
`define RCS_MEAS_PERIOD_CYC  (`RCS_MEAS_PERIOD_MS * 1000 * `RCS_CLK_MHZ)

// ----------------------------------------------------------------
// sensor supervision counts, in measurement results
// ----------------------------------------------------------------
`define RCS_FAIL_CNT         3
`define RCS_OK_CNT           5

// ----------------------------------------------------------------
// value ranges: temperature 0.1 K, humidity 0.1 %, co2 1 ppm
// ----------------------------------------------------------------
`define RCS_CO2_MAX          16'h07D0
`define RCS_HUM_FULL         16'h03E8
`define RCS_HUM_MIN          16'h0064
`define RCS_HUM_MAX          16'h03B6
`define RCS_HUM_COMP_SH      7
`define RCS_DEW_MUL          18'h000CD
`define RCS_DEW_SH           10

// ----------------------------------------------------------------
// co2 limit defaults and alarm encodings
// ----------------------------------------------------------------
`define RCS_LIM0_DEF         16'h0190
`define RCS_LIM1_DEF         16'h0320
`define RCS_LIM2_DEF         16'h04B0
`define RCS_LIM3_DEF         16'h0640
`define RCS_BYTE_ON          8'hFF
`define RCS_BYTE_OFF         8'h00

`endif

// ==== pkg/rcs_pkg.sv ====
package rcs_pkg;

  // source of the actual room temperature
  typedef enum logic [1:0] {
    RCS_SRC_INT = 2'b00,
    RCS_SRC_EXT = 2'b01,
    RCS_SRC_AVG = 2'b10
  } rcs_src_t;

  // supervision state of one integrated sensor
  typedef enum logic {
    RCS_ST_RUN   = 1'b0,
    RCS_ST_DEACT = 1'b1
  } rcs_fst_t;

endpackage

// ==== rtl/rcs_fault_mon.sv ====
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_fault_mon
  import rcs_pkg::*;
#(
  parameter int unsigned FAIL_N = `RCS_FAIL_CNT,
  parameter int unsigned OK_N   = `RCS_OK_CNT
) (
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  input  wire logic i_done,
  input  wire logic i_ok,
  output logic      o_run_next,
  output logic      o_fault,
  output logic      o_evt
);

  if (FAIL_N < 1 || FAIL_N > 15 || OK_N < 1 || OK_N > 15) begin : g_bad_cnt
    $error("rcs_fault_mon: counts must be 1 to 15");
  end

  rcs_fst_t   state_q;
  rcs_fst_t   state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       reported_q;

  // ----------------------------------------------------------------
  // run / deactivated sequence
  // ----------------------------------------------------------------
  // counts only consecutive results, a single good reply does not end a fault
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (i_done) begin
      case (state_q)
        RCS_ST_RUN: begin
          if (i_ok) begin
            cnt_d = 4'h0;
          end else if (cnt_q == 4'(FAIL_N - 1)) begin
            state_d = RCS_ST_DEACT;
            cnt_d   = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        RCS_ST_DEACT: begin
          if (!i_ok) begin
            cnt_d = 4'h0;
          end else if (cnt_q == 4'(OK_N - 1)) begin
            state_d = RCS_ST_RUN;
            cnt_d   = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        default: begin
          state_d = RCS_ST_RUN;
          cnt_d   = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= RCS_ST_RUN;
      cnt_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // fault telegram
  // ----------------------------------------------------------------
  // report after reset
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reported_q <= 1'b0;
      o_evt      <= 1'b0;
    end else begin
      o_evt <= i_done && (!reported_q || state_d != state_q);
      if (i_done) begin
        reported_q <= 1'b1;
      end
    end
  end

  assign o_run_next = (state_d == RCS_ST_RUN);
  assign o_fault    = (state_q == RCS_ST_DEACT);

  fault_entry_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_fault) |-> $past(i_done && !i_ok) && o_evt)
    else $error("fault set without failed result or telegram");

  fault_exit_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $fell(o_fault) |-> $past(i_done && i_ok) && o_evt)
    else $error("fault cleared without good result or telegram");

  first_report_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_done && !reported_q |=> o_evt)
    else $error("no fault telegram after reset");

endmodule

// ==== rtl/rcs_supervisor.sv ====
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_supervisor
  import rcs_pkg::*;
#(
  parameter int unsigned MEAS_CYC = `RCS_MEAS_PERIOD_CYC,
  parameter int unsigned FAIL_N   = `RCS_FAIL_CNT,
  parameter int unsigned OK_N     = `RCS_OK_CNT
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  output logic             o_meas_req,
  input  wire logic        i_temp_done,
  input  wire logic        i_temp_ok,
  input  wire logic [15:0] i_temp_raw,
  input  wire logic        i_hum_done,
  input  wire logic        i_hum_ok,
  input  wire logic [15:0] i_hum_raw,
  input  wire logic        i_co2_done,
  input  wire logic        i_co2_ok,
  input  wire logic [15:0] i_co2_raw,
  input  wire logic        i_ext_temp_valid,
  input  wire logic [15:0] i_ext_temp,
  input  wire logic [1:0]  i_temp_src,
  input  wire logic [15:0] i_temp_offset,
  input  wire logic [15:0] i_dew_lead,
  input  wire logic [15:0] i_dew_hyst,
  input  wire logic        i_dew_two_out,
  input  wire logic        i_dew_fmt_byte,
  input  wire logic        i_lim_wr,
  input  wire logic [1:0]  i_lim_sel,
  input  wire logic [15:0] i_lim_value,
  input  wire logic [15:0] i_lim_hyst,
  input  wire logic [3:0]  i_lim_dir,
  output logic             o_temp_valid,
  output logic [15:0]      o_temp_value,
  output logic             o_hum_valid,
  output logic [15:0]      o_hum_value,
  output logic [15:0]      o_dew_value,
  output logic             o_dew_evt,
  output logic [1:0]       o_dew_bit,
  output logic [7:0]       o_dew_byte0,
  output logic [7:0]       o_dew_byte1,
  output logic             o_co2_valid,
  output logic [15:0]      o_co2_value,
  output logic [3:0]       o_lim_state,
  output logic [3:0]       o_lim_evt,
  output logic [2:0]       o_fault,
  output logic [2:0]       o_fault_evt
);

  if (MEAS_CYC < 2) begin : g_bad_period
    $error("rcs_supervisor: MEAS_CYC must be at least 2");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07FFF) begin
      return 16'sh7FFF;
    end else if (v < -18'sh08000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction

  // hysteresis switch: dir high means on above the limit
  function automatic logic lim_next(input logic st, input logic [15:0] v,
                                    input logic [15:0] lim, input logic [15:0] hy,
                                    input logic dir);
    logic [16:0] up;
    logic [16:0] dn;
    up = {1'b0, lim} + {1'b0, hy};
    dn = {1'b0, lim} - {1'b0, hy};
    if (dir) begin
      return st ? !(dn[16] ? 1'b0 : ({1'b0, v} < dn)) : (v > lim);
    end
    return st ? !({1'b0, v} > up) : (v < lim);
  endfunction

  // ----------------------------------------------------------------
  // measurement cycle divider
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_q;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_q <= 32'h0;
      o_meas_req <= 1'b0;
    end else begin
      o_meas_req <= (tick_cnt_q == 32'h0);
      if (tick_cnt_q == MEAS_CYC - 1) begin
        tick_cnt_q <= 32'h0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sensor supervision, index 0 temp, 1 humidity, 2 co2
  // ----------------------------------------------------------------
  logic [2:0] done_v;
  logic [2:0] ok_v;
  logic [2:0] run_next;

  assign done_v = {i_co2_done, i_hum_done, i_temp_done};
  assign ok_v   = {i_co2_ok, i_hum_ok, i_temp_ok};

  for (genvar k = 0; k < 3; k++) begin : g_mon
    rcs_fault_mon #(
      .FAIL_N (FAIL_N),
      .OK_N   (OK_N)
    ) u_mon (
      .i_mclk     (i_mclk),
      .i_reset_n  (i_reset_n),
      .i_done     (done_v[k]),
      .i_ok       (ok_v[k]),
      .o_run_next (run_next[k]),
      .o_fault    (o_fault[k]),
      .o_evt      (o_fault_evt[k])
    );
  end

  // ----------------------------------------------------------------
  // temperature
  // ----------------------------------------------------------------
  logic signed [15:0] ext_q;
  logic               ext_seen_q;
  logic signed [15:0] t_adj;
  logic signed [15:0] t_act;
  logic signed [15:0] t_pub;
  logic signed [15:0] t_room_q;
  logic signed [15:0] t_sens_q;
  logic               room_ok_q;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_q      <= 16'sh0000;
      ext_seen_q <= 1'b0;
    end else if (i_ext_temp_valid) begin
      ext_q      <= i_ext_temp;
      ext_seen_q <= 1'b1;
    end
  end

  // source select; until an external value arrives the internal one stands in
  always_comb begin
    t_adj = sat16(18'(signed'(i_temp_raw)) + 18'(signed'(i_temp_offset)));
    t_act = t_adj;
    t_pub = run_next[0] ? t_adj : 16'sh0000;
    if (ext_seen_q) begin
      case (rcs_src_t'(i_temp_src))
        RCS_SRC_EXT: begin
          t_act = ext_q;
          t_pub = ext_q;
        end
        RCS_SRC_AVG: begin
          t_act = run_next[0] ? sat16((18'(t_adj) + 18'(ext_q)) >>> 1) : ext_q;
          t_pub = t_act;
        end
        default: begin
          t_act = t_adj;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_temp_valid <= 1'b0;
      o_temp_value <= 16'h0000;
      t_room_q     <= 16'sh0000;
      t_sens_q     <= 16'sh0000;
      room_ok_q    <= 1'b0;
    end else begin
      o_temp_valid <= i_temp_done;
      if (i_temp_done) begin
        o_temp_value <= t_pub;
        if (run_next[0] || ext_seen_q) begin
          t_room_q  <= t_act;
          t_sens_q  <= i_temp_raw;
          room_ok_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // humidity and dew point
  // ----------------------------------------------------------------
  logic signed [17:0] t_delta;
  logic signed [33:0] comp;
  logic signed [17:0] rh_wide;
  logic [15:0]        rh_corr;
  logic signed [17:0] dew_pt;
  logic signed [17:0] dew_thr;
  logic signed [17:0] dew_off;
  logic               dew_q;
  logic               dew_d;
  logic               dew_eval;

  always_comb begin
    t_delta = 18'(t_room_q) - 18'(t_sens_q);
    comp    = signed'({18'h0, i_hum_raw}) * 34'(t_delta);
    rh_wide = 18'(signed'({2'b00, i_hum_raw})) - 18'(comp >>> `RCS_HUM_COMP_SH);
    if (rh_wide < 18'sh0) begin
      rh_corr = 16'h0000;
    end else if (rh_wide > 18'(`RCS_HUM_FULL)) begin
      rh_corr = `RCS_HUM_FULL;
    end else begin
      rh_corr = rh_wide[15:0];
    end
  end

  // dew point, linearised Magnus slope; coarse below about 50 % humidity
  always_comb begin
    dew_pt  = 18'(t_room_q) - 18'((18'(`RCS_HUM_FULL - rh_corr) * `RCS_DEW_MUL) >> `RCS_DEW_SH);
    dew_thr = dew_pt + 18'(signed'(i_dew_lead));
    dew_off = dew_thr + 18'(signed'(i_dew_hyst));
    dew_eval = i_hum_done && run_next[1] && room_ok_q;
    dew_d = dew_q;
    if (dew_eval) begin
      dew_d = dew_q ? !(18'(t_room_q) > dew_off) : (18'(t_room_q) <= dew_thr);
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hum_valid <= 1'b0;
      o_hum_value <= 16'h0000;
      o_dew_value <= 16'h0000;
    end else begin
      o_hum_valid <= i_hum_done;
      if (i_hum_done) begin
        o_hum_value <= run_next[1] ? rh_corr : 16'h0000;
      end
      if (dew_eval) begin
        o_dew_value <= sat16(dew_pt);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dew_q       <= 1'b0;
      o_dew_evt   <= 1'b0;
      o_dew_bit   <= 2'b00;
      o_dew_byte0 <= `RCS_BYTE_OFF;
      o_dew_byte1 <= `RCS_BYTE_OFF;
    end else begin
      dew_q       <= dew_d;
      o_dew_evt   <= dew_eval && (dew_d != dew_q);
      o_dew_bit   <= i_dew_fmt_byte ? 2'b00 : {i_dew_two_out && !dew_d, dew_d};
      o_dew_byte0 <= (i_dew_fmt_byte && dew_d) ? `RCS_BYTE_ON : `RCS_BYTE_OFF;
      o_dew_byte1 <= (i_dew_fmt_byte && i_dew_two_out && !dew_d) ? `RCS_BYTE_ON : `RCS_BYTE_OFF;
    end
  end

  // ----------------------------------------------------------------
  // co2 and limit values
  // ----------------------------------------------------------------
  logic [15:0] co2_v;
  logic [15:0] lim_q [4];
  logic [3:0]  lim_d;

  assign co2_v = !run_next[2] ? 16'h0000 : (i_co2_raw > `RCS_CO2_MAX) ? `RCS_CO2_MAX : i_co2_raw;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lim_q[0] <= `RCS_LIM0_DEF;
      lim_q[1] <= `RCS_LIM1_DEF;
      lim_q[2] <= `RCS_LIM2_DEF;
      lim_q[3] <= `RCS_LIM3_DEF;
    end else if (i_lim_wr) begin
      lim_q[i_lim_sel] <= i_lim_value;
    end
  end

  // hysteresis per limit
  // skipped while deactivated so the forced zero cannot trip an undershoot
  always_comb begin
    lim_d = o_lim_state;
    for (int i = 0; i < 4; i++) begin
      if (i_co2_done && run_next[2]) begin
        lim_d[i] = lim_next(o_lim_state[i], co2_v, lim_q[i], i_lim_hyst, i_lim_dir[i]);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_co2_valid <= 1'b0;
      o_co2_value <= 16'h0000;
      o_lim_state <= 4'h0;
      o_lim_evt   <= 4'h0;
    end else begin
      o_co2_valid <= i_co2_done;
      if (i_co2_done) begin
        o_co2_value <= co2_v;
      end
      o_lim_state <= lim_d;
      o_lim_evt <= lim_d ^ o_lim_state;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  req_first_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(i_reset_n) ##1 1'b1 |-> o_meas_req)
    else $error("no measurement request after reset");

  temp_zero_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_temp_valid && o_fault[0] && $past(i_temp_src) == RCS_SRC_INT |-> o_temp_value == 16'h0000)
    else $error("faulty temperature sensor reports nonzero");

  hum_zero_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_hum_valid && o_fault[1] |-> o_hum_value == 16'h0000)
    else $error("faulty humidity sensor reports nonzero");

  co2_range_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_co2_valid |-> o_co2_value <= `RCS_CO2_MAX && (o_fault[2] -> o_co2_value == 16'h0000))
    else $error("co2 value out of range");

  lim_evt_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_lim_evt[0] |-> o_lim_state[0] != $past(o_lim_state[0]) && $past(i_co2_done))
    else $error("limit telegram without change or new value");

  dew_evt_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(dew_q) |-> o_dew_evt && $past(i_hum_done))
    else $error("dew alarm change without telegram");

  dew_byte_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    dew_q && $past(i_dew_fmt_byte) |-> o_dew_byte0 == `RCS_BYTE_ON && o_dew_bit == 2'b00)
    else $error("dew alarm byte encoding wrong");

endmodule

// ==== verif/rcs_sensor_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// sensor front end: answers each request after a set delay
// ----------------------------------------------------------------
module rcs_sensor_model (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_req,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_ok,
  input  wire logic [15:0] i_raw,
  output logic             o_done,
  output logic             o_ok,
  output logic [15:0]      o_raw
);
  logic       req;
  logic       busy;
  logic [3:0] cnt;

  // result lines carry garbage outside the strobe, so a design that
  // samples them at the wrong edge sees inverted data, not a lucky match
  initial begin
    o_done = 1'b0;
    o_ok   = 1'b0;
    o_raw  = 16'h0000;
    busy   = 1'b0;
    cnt    = 4'h0;
    forever begin
      @(posedge i_mclk);
      req = i_req;
      #1;
      if (!i_reset_n) begin
        busy   = 1'b0;
        o_done = 1'b0;
      end else begin
        if (o_done) begin
          o_done = 1'b0;
          o_ok   = ~o_ok;
          o_raw  = ~o_raw;
        end
        if (req) begin
          busy = 1'b1;
          cnt  = i_delay;
        end else if (busy) begin
          cnt = cnt - 4'h1;
          if (cnt == 4'h0) begin
            busy   = 1'b0;
            o_done = 1'b1;
            o_ok   = i_ok;
            o_raw  = i_raw;
          end
        end
      end
    end
  end
endmodule

// ==== verif/rcs_supervisor_tb_top.sv ====
`timescale 1ns/1ps

module rcs_supervisor_tb_top;
  import rcs_pkg::*;
  localparam int unsigned MEAS  = 40;
  localparam int unsigned LIMIT = 4000;

  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  logic        i_mclk    = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        meas_req, t_done, t_ok, h_done, h_ok, c_done, c_ok;
  logic [15:0] t_raw, h_raw, c_raw;
  logic        ext_vld = 1'b0, two_out = 1'b0, fmt_byte = 1'b0, lim_wr = 1'b0, c_cfg_ok = 1'b1;
  logic        t_cfg_ok = 1'b1, h_cfg_ok = 1'b1;
  logic [1:0]  src = 2'b00, lim_sel = 2'b00;
  logic [15:0] ext_t = 16'h0000, offs = 16'h0000, lead = 16'h0000, dhyst = 16'h0000;
  logic [15:0] lim_val = 16'h0000, lim_hyst = 16'h0014;
  logic [3:0]  lim_dir = 4'hF;
  logic [15:0] t_cfg = 16'h00C8, h_cfg = 16'h01F4, c_cfg = 16'h0384;
  logic        t_vld, h_vld, c_vld, dew_evt;
  logic [15:0] t_val, h_val, c_val, dew_val;
  logic [1:0]  dew_bit;
  logic [7:0]  dew_b0, dew_b1;
  logic [3:0]  lim_st, lim_evt, lim_acc;
  logic [2:0]  flt, flt_evt, flt_acc, vld_acc;
  logic        dew_acc;
  int          bad_count = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          n;
  int          co2_in[5]  = '{1700, 1700, 1590, 1570, 2500};
  int          co2_out[5] = '{1700, 1700, 1590, 1570, 2000};
  logic [3:0]  st_exp[5]  = '{4'hF, 4'hF, 4'hF, 4'h7, 4'hF};
  logic [3:0]  ev_exp[5]  = '{4'hC, 4'h0, 4'h0, 4'h8, 4'h8};

  always #5 i_mclk = ~i_mclk;

  rcs_supervisor #(.MEAS_CYC(MEAS), .FAIL_N(3), .OK_N(5)) rcs_supervisor_inst (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .o_meas_req(meas_req),
    .i_temp_done(t_done), .i_temp_ok(t_ok), .i_temp_raw(t_raw),
    .i_hum_done(h_done), .i_hum_ok(h_ok), .i_hum_raw(h_raw),
    .i_co2_done(c_done), .i_co2_ok(c_ok), .i_co2_raw(c_raw),
    .i_ext_temp_valid(ext_vld), .i_ext_temp(ext_t), .i_temp_src(src), .i_temp_offset(offs),
    .i_dew_lead(lead), .i_dew_hyst(dhyst), .i_dew_two_out(two_out), .i_dew_fmt_byte(fmt_byte),
    .i_lim_wr(lim_wr), .i_lim_sel(lim_sel), .i_lim_value(lim_val), .i_lim_hyst(lim_hyst),
    .i_lim_dir(lim_dir), .o_temp_valid(t_vld), .o_temp_value(t_val), .o_hum_valid(h_vld),
    .o_hum_value(h_val), .o_dew_value(dew_val), .o_dew_evt(dew_evt), .o_dew_bit(dew_bit),
    .o_dew_byte0(dew_b0), .o_dew_byte1(dew_b1), .o_co2_valid(c_vld), .o_co2_value(c_val),
    .o_lim_state(lim_st), .o_lim_evt(lim_evt), .o_fault(flt), .o_fault_evt(flt_evt));

  // temperature answers first so the dew point pairs with a fresh value
  rcs_sensor_model rcs_sensor_model_inst_t (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(meas_req),
    .i_delay(4'h2), .i_ok(t_cfg_ok), .i_raw(t_cfg), .o_done(t_done), .o_ok(t_ok), .o_raw(t_raw));
  rcs_sensor_model rcs_sensor_model_inst_h (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(meas_req),
    .i_delay(4'h4), .i_ok(h_cfg_ok), .i_raw(h_cfg), .o_done(h_done), .o_ok(h_ok), .o_raw(h_raw));
  rcs_sensor_model rcs_sensor_model_inst_c (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(meas_req),
    .i_delay(4'h6), .i_ok(c_cfg_ok), .i_raw(c_cfg), .o_done(c_done), .o_ok(c_ok), .o_raw(c_raw));

  // ----------------------------------------------------------------
  // event capture, timeout and helper tasks
  // ----------------------------------------------------------------
  // one-cycle pulses are collected so a late sample cannot miss them
  always @(posedge i_mclk) begin
    lim_acc = lim_acc | lim_evt;
    dew_acc = dew_acc | dew_evt;
    flt_acc = flt_acc | flt_evt;
    vld_acc = vld_acc | {c_vld, h_vld, t_vld};
    cyc     = cyc + 1;
    if (cyc == LIMIT) begin
      bad_count = bad_count + 1;
      results();
    end
  end

  task automatic step(input int k);
    repeat (k) begin
      @(posedge i_mclk);
      #1;
    end
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // set sensor replies, then let one full request/answer round pass
  task automatic meas(input logic [15:0] t, input logic [15:0] h, input logic [15:0] c, input logic ok);
    int k;
    t_cfg    = t;
    h_cfg    = h;
    c_cfg    = c;
    c_cfg_ok = ok;
    lim_acc  = 4'h0;
    dew_acc  = 1'b0;
    flt_acc  = 3'h0;
    vld_acc  = 3'h0;
    k = 0;
    while (meas_req !== 1'b1 && k < 200) begin
      step(1);
      k = k + 1;
    end
    step(12);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    lim_acc = 4'h0;
    dew_acc = 1'b0;
    flt_acc = 3'h0;
    step(8);
    check({12'h000, lim_st}, 16'h0000); // idle
    check({13'h0000, flt}, 16'h0000); // idle
    i_reset_n = 1'b1;
    meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
    check(t_val, 16'h00C8);
    check(h_val, 16'h01F4);
    check(c_val, 16'h0384);
    check({12'h000, lim_st}, 16'h0003);
    check({12'h000, lim_acc}, 16'h0003);
    check({13'h0000, flt_acc}, 16'h0007);
    check({13'h0000, flt}, 16'h0000);
    check(dew_val, 16'h0064);
    check({14'h0000, dew_bit}, 16'h0000);
    // request spacing
    n = 0;
    while (meas_req !== 1'b1 && n < 200) begin step(1); n++; end
    n = 0;
    do begin step(1); n++; end while (meas_req !== 1'b1 && n < 200);
    check(n[15:0], MEAS[15:0]);
    // limit crossings with hysteresis 20 ppm and clamping
    for (int i = 0; i < 5; i++) begin
      meas(16'h00C8, 16'h01F4, co2_in[i][15:0], 1'b1);
      check(c_val, co2_out[i][15:0]);
      check({12'h000, lim_st}, {12'h000, st_exp[i]});
      check({12'h000, lim_acc}, {12'h000, ev_exp[i]});
    end
    lim_sel = 2'b00;
    lim_val = 16'h03E8;
    lim_wr  = 1'b1;
    step(1);
    lim_wr = 1'b0;
    meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
    check({12'h000, lim_st}, 16'h0002);
    check({12'h000, lim_acc}, 16'h000D);
    lim_dir = 4'hE;
    meas(16'h00C8, 16'h01F4, 16'h012C, 1'b1);
    check({12'h000, lim_st}, 16'h0001);
    // sensor failure and recovery
    for (int i = 0; i < 3; i++) begin
      meas(16'h00C8, 16'h01F4, 16'h0384, 1'b0);
      check(c_val, (i == 2) ? 16'h0000 : 16'h0384);
      check({15'h0000, flt[2]}, (i == 2) ? 16'h0001 : 16'h0000);
      check({13'h0000, flt_acc}, (i == 2) ? 16'h0004 : 16'h0000);
    end
    for (int i = 0; i < 5; i++) begin
      meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
      if (i == 0) check(c_val, 16'h0000);
      check({15'h0000, flt[2]}, (i == 4) ? 16'h0000 : 16'h0001);
      check({13'h0000, flt_acc}, (i == 4) ? 16'h0004 : 16'h0000);
    end
    // dew alarm: room temperature sits 10.0 K above the dew point
    lead = 16'h0078;
    meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
    check({15'h0000, dew_acc}, 16'h0001);
    check({14'h0000, dew_bit}, 16'h0001);
    two_out = 1'b1;
    step(2);
    check({14'h0000, dew_bit}, 16'h0001);
    fmt_byte = 1'b1;
    step(2);
    check({dew_b1, dew_b0}, 16'h00FF);
    check({14'h0000, dew_bit}, 16'h0000);
    lead  = 16'h0050;
    dhyst = 16'h001E;
    meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
    check({15'h0000, dew_acc}, 16'h0000);
    check({dew_b1, dew_b0}, 16'h00FF);
    lead = 16'h003C;
    meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
    check({15'h0000, dew_acc}, 16'h0001);
    check({dew_b1, dew_b0}, 16'hFF00);
    // temperature offset feeds humidity correction and dew point
    offs = 16'h000A;
    meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
    check(t_val, 16'h00D2);
    check(h_val, 16'h01CD);
    check(dew_val, 16'h0067);
    offs = 16'h0000;
    // external sensor as replacement and as partner in the average
    ext_t   = 16'h00FA;
    ext_vld = 1'b1;
    step(1);
    ext_vld = 1'b0;
    src     = 2'b01;
    meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
    check(t_val, 16'h00FA);
    src = 2'b10;
    meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
    check(t_val, 16'h00E1);
    // temperature and humidity replies failing together, internal source
    src      = 2'b00;
    t_cfg_ok = 1'b0;
    h_cfg_ok = 1'b0;
    for (int i = 0; i < 3; i++) begin
      meas(16'h00C8, 16'h01F4, 16'h0384, 1'b1);
      check(t_val, (i == 2) ? 16'h0000 : 16'h00C8);
      check(h_val, (i == 2) ? 16'h0000 : 16'h01F4);
      check({13'h0000, flt}, (i == 2) ? 16'h0003 : 16'h0000);
      check({13'h0000, vld_acc}, 16'h0007);
    end
    results();
  end
endmodule
